/* hdl/sfe_pkg.sv */
// constants, states and types for the erase and power-mode sequencer
// Overview of operation
// RQ1 - accepted page erase sets every bit of the addressed page to one
// RQ2 - erase instructions need the write unlock latch set beforehand, else ignored
// RQ3 - page erase frame is opcode plus three address bytes; A23 to A19 ignored
// RQ4 - erase frames execute only when select rises right after the 32nd bit
// RQ5 - select rise after valid erase starts a timed cycle; busy flag high meanwhile
// RQ6 - write unlock latch is cleared before each erase cycle finishes
// RQ7 - accepted sector erase sets every bit of the containing sector to one
// RQ8 - no erase of a protected page or a sector holding one
// RQ9 - while a cycle runs, erase, sleep and wake frames are rejected
// RQ10 - sleep frame is the opcode alone, select rising after its eighth bit
// RQ11 - deep sleep is entered a sleep entry delay after the frame ends
// RQ12 - in deep sleep every instruction except wake is ignored
// RQ13 - deselect with no cycle running gives standby, never deep sleep
// RQ14 - deep sleep ends at power loss; power-on always comes up in standby
// RQ15 - wake frame is the opcode only; extra clocks reject it
// RQ16 - standby returns a wake delay after the wake frame ends
// RQ17 - power-on reset holds all logic reset and answers no instruction
// RQ18 - modifying instructions are ignored until the write lockout delay passes
// RQ19 - host waits at least 30 us after supply before selecting
// RQ20 - at power-up latch and busy are clear and the mode is standby
// RQ21 - opcode values are configurable parameters
// RQ22 - cycle and mode delays are parameters counted in core clock cycles
package sfe_pkg;
  localparam int CLK_MHZ       = 25;
  // longest permitted lockout, so no unlock slips in too early
  localparam int LOCKOUT_US    = 10000;
  localparam int LOCKOUT_CYC   = LOCKOUT_US * CLK_MHZ;
  localparam int SEL_AFTER_US  = 30;

  localparam logic [7:0] OPC_UNLOCK = 8'h10;
  localparam logic [7:0] OPC_PG_CLR = 8'h20;
  localparam logic [7:0] OPC_SC_CLR = 8'h30;
  localparam logic [7:0] OPC_SLEEP  = 8'h40;
  localparam logic [7:0] OPC_WAKE   = 8'h50;

  localparam int PAGE_CLR_CYC_DEF = 64;
  localparam int SECT_CLR_CYC_DEF = 256;
  localparam int SLEEP_CYC_DEF    = 8;
  localparam int WAKE_CYC_DEF     = 8;

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FRM_OP_BITS   = 6'h08;
  localparam logic [CNT_W-1:0] FRM_ADDR_BITS = 6'h20;
  localparam logic [CNT_W-1:0] CNT_SAT       = 6'h3F;
  localparam logic [CNT_W-1:0] CNT_ONE       = 6'h01;
  localparam logic [CNT_W-1:0] CNT_RST       = 6'h00;

  localparam int SH_W     = 32;
  localparam int OPH_LSB  = 24;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_MSB = 18;
  localparam int SECT_LSB = 16;
  localparam int SECT_MSB = 18;
  localparam logic [SH_W-1:0] SH_RST = 32'h0000_0000;
  localparam logic [2:0] SECT_PROT    = 3'h0;
  localparam logic [10:0] PAGE_RST    = 11'h000;

  localparam int TMR_W = 20;
  typedef logic [TMR_W-1:0] sfe_tmr_t;
  localparam sfe_tmr_t TMR_ZERO = 20'h00000;
  localparam sfe_tmr_t TMR_ONE  = 20'h00001;

  typedef enum logic [2:0] {
    ST_STANDBY     = 3'b000,
    ST_ERASE       = 3'b001,
    ST_SLEEP_ENTRY = 3'b010,
    ST_SLEEP       = 3'b011,
    ST_WAKE        = 3'b100
  } sfe_state_e;
endpackage

/* hdl/sfe_ctrl.sv */
// erase, deep sleep and power-up lockout sequencer of the serial flash
`timescale 1ns/100ps
module sfe_ctrl #(
  parameter logic [7:0] OPC_UNLOCK_P = sfe_pkg::OPC_UNLOCK, // see RQ21
  parameter logic [7:0] OPC_PG_CLR_P = sfe_pkg::OPC_PG_CLR,
  parameter logic [7:0] OPC_SC_CLR_P = sfe_pkg::OPC_SC_CLR,
  parameter logic [7:0] OPC_SLEEP_P  = sfe_pkg::OPC_SLEEP,
  parameter logic [7:0] OPC_WAKE_P   = sfe_pkg::OPC_WAKE,
  parameter int PAGE_CLR_CYC = sfe_pkg::PAGE_CLR_CYC_DEF,
  parameter int SECT_CLR_CYC = sfe_pkg::SECT_CLR_CYC_DEF,
  parameter int SLEEP_CYC    = sfe_pkg::SLEEP_CYC_DEF,
  parameter int WAKE_CYC     = sfe_pkg::WAKE_CYC_DEF,
  parameter int LOCKOUT_CYC  = sfe_pkg::LOCKOUT_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDI,
  input  wire logic        PROT_SECT0,
  input  wire logic        EXT_CYCLE_BUSY,
  output logic             BUSY_FLAG,
  output logic             WRITE_UNLOCK_LATCH,
  output logic             DEEP_SLEEP,
  output logic             STANDBY,
  output logic             LOCKOUT,
  output logic             ERASE_STB,
  output logic             ERASE_SECTOR,
  output logic [10:0]      ERASE_PAGE
);
  import sfe_pkg::*;

  function automatic logic frame_is(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] len,
    input logic [7:0]       got,
    input logic [7:0]       want
  );
    frame_is = (cnt == len) && (got == want);
  endfunction

  function automatic logic [2:0] sector_of(input logic [SH_W-1:0] sh);
    sector_of = sh[SECT_MSB:SECT_LSB];
  endfunction

  function automatic sfe_tmr_t load_of(input int cyc);
    load_of = sfe_tmr_t'(cyc - 1);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link side, clocked by the host serial clock
  logic [SH_W-1:0]  sh_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             in_frame_reg;

  // select high clears only the frame marker; count survives for the core
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg <= CNT_RST;
    end else if (!in_frame_reg) begin
      cnt_reg <= CNT_ONE;
    end else if (cnt_reg != CNT_SAT) begin
      cnt_reg <= cnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_reg <= SH_RST;
    end else begin
      sh_reg <= {sh_reg[SH_W-2:0], SDI};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // crossings: frame words are quiet once select is high, so two stages do
  logic                  cs_m_reg;
  logic                  cs_s_reg;
  logic                  cs_d_reg;
  logic                  prot_m_reg;
  logic                  prot_s_reg;
  logic [CNT_W+SH_W-1:0] snap_m_reg;
  logic [CNT_W+SH_W-1:0] snap_s_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cs_m_reg <= 1'b1;
      cs_s_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      prot_m_reg <= 1'b1;
      prot_s_reg <= 1'b1;
    end else begin
      cs_m_reg <= CS_N;
      cs_s_reg <= cs_m_reg;
      cs_d_reg <= cs_s_reg;
      prot_m_reg <= PROT_SECT0;
      prot_s_reg <= prot_m_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      snap_m_reg <= {CNT_RST, SH_RST};
      snap_s_reg <= {CNT_RST, SH_RST};
    end else begin
      snap_m_reg <= {cnt_reg, sh_reg};
      snap_s_reg <= snap_m_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frame decode at the synchronised select rise
  logic [CNT_W-1:0] f_cnt;
  logic [SH_W-1:0]  f_sh;
  logic             fr_end;
  logic             dec_unlock;
  logic             dec_pg;
  logic             dec_sc;
  logic             dec_sleep;
  logic             dec_wake;
  logic             prot_hit;

  assign f_cnt  = snap_s_reg[CNT_W+SH_W-1:SH_W];
  assign f_sh   = snap_s_reg[SH_W-1:0];
  assign fr_end = cs_s_reg && !cs_d_reg;
  assign dec_unlock = frame_is(f_cnt, FRM_OP_BITS, f_sh[7:0], OPC_UNLOCK_P);
  // only exact 32-bit frames count; the opcode sits in the first byte
  assign dec_pg = frame_is(f_cnt, FRM_ADDR_BITS, f_sh[SH_W-1:OPH_LSB],
                           OPC_PG_CLR_P); // see RQ3, see RQ4
  assign dec_sc = frame_is(f_cnt, FRM_ADDR_BITS, f_sh[SH_W-1:OPH_LSB],
                           OPC_SC_CLR_P); // see RQ4
  assign dec_sleep = frame_is(f_cnt, FRM_OP_BITS, f_sh[7:0],
                              OPC_SLEEP_P); // see RQ10
  // extra clocks push the count past eight and spoil the match
  assign dec_wake = frame_is(f_cnt, FRM_OP_BITS, f_sh[7:0],
                             OPC_WAKE_P); // see RQ15
  // only the bottom sector can be protected, so page and sector agree
  assign prot_hit = prot_s_reg && (sector_of(f_sh) == SECT_PROT); // see RQ8

  //////////////////////////////////////////////////////////////////////////
  // power-up write lockout
  sfe_tmr_t lk_reg;
  logic     lock_done_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lk_reg <= load_of(LOCKOUT_CYC); // see RQ18
      lock_done_reg <= 1'b0;
    end else if (lk_reg != TMR_ZERO) begin
      lk_reg <= lk_reg - TMR_ONE;
    end else begin
      lock_done_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  sfe_state_e state_reg;
  sfe_state_e state_next;
  sfe_tmr_t   tmr_reg;
  logic       unlk_reg;
  logic       start_erase;
  logic       idle_ok;

  // a program or write cycle elsewhere blocks us as much as our own
  assign idle_ok = (state_reg == ST_STANDBY) && !EXT_CYCLE_BUSY; // see RQ9
  assign start_erase = fr_end && idle_ok && lock_done_reg && unlk_reg &&
                       (dec_pg || dec_sc) && !prot_hit; // see RQ2, see RQ8

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY: begin
        if (start_erase) begin
          state_next = ST_ERASE; // see RQ5
        end else if (fr_end && idle_ok && dec_sleep) begin
          state_next = ST_SLEEP_ENTRY; // see RQ11
        end
      end
      ST_ERASE: begin
        // frames arriving now are dropped; the cycle runs on
        if (tmr_reg == TMR_ZERO) begin
          state_next = ST_STANDBY; // see RQ9
        end
      end
      ST_SLEEP_ENTRY: begin
        if (tmr_reg == TMR_ZERO) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (fr_end && dec_wake) begin
          state_next = ST_WAKE; // see RQ12, see RQ15
        end
      end
      ST_WAKE: begin
        if (tmr_reg == TMR_ZERO) begin
          state_next = ST_STANDBY; // see RQ16
        end
      end
      default: begin
        state_next = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg <= ST_STANDBY; // see RQ14, see RQ17, see RQ20
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tmr_reg <= TMR_ZERO;
    end else if (state_next != state_reg) begin
      case (state_next)
        ST_ERASE: begin
          tmr_reg <= dec_sc ? load_of(SECT_CLR_CYC)
                            : load_of(PAGE_CLR_CYC); // see RQ22
        end
        ST_SLEEP_ENTRY: begin
          tmr_reg <= load_of(SLEEP_CYC); // see RQ11
        end
        ST_WAKE: begin
          tmr_reg <= load_of(WAKE_CYC); // see RQ16
        end
        default: begin
          tmr_reg <= TMR_ZERO;
        end
      endcase
    end else if (tmr_reg != TMR_ZERO) begin
      tmr_reg <= tmr_reg - TMR_ONE;
    end
  end

  // cleared as the erase starts, well before it finishes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      unlk_reg <= 1'b0; // see RQ20
    end else if (fr_end && idle_ok && lock_done_reg && dec_unlock) begin
      unlk_reg <= 1'b1; // see RQ18
    end else if (start_erase) begin
      unlk_reg <= 1'b0; // see RQ6
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BUSY_FLAG <= 1'b0;
      WRITE_UNLOCK_LATCH <= 1'b0;
      DEEP_SLEEP <= 1'b0;
      STANDBY <= 1'b0;
      LOCKOUT <= 1'b1;
    end else begin
      BUSY_FLAG <= (state_next == ST_ERASE); // see RQ5
      WRITE_UNLOCK_LATCH <= unlk_reg;
      DEEP_SLEEP <= (state_next == ST_SLEEP); // see RQ12
      // deselect alone only ever gives standby
      STANDBY <= (state_next == ST_STANDBY) && cs_s_reg &&
                 !EXT_CYCLE_BUSY; // see RQ13
      LOCKOUT <= !lock_done_reg;
    end
  end

  // the array clears the whole page or sector on this strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ERASE_STB <= 1'b0;
      ERASE_SECTOR <= 1'b0;
      ERASE_PAGE <= PAGE_RST;
    end else begin
      ERASE_STB <= start_erase; // see RQ1, see RQ7
      if (start_erase) begin
        ERASE_SECTOR <= dec_sc; // see RQ7
        ERASE_PAGE <= f_sh[PAGE_MSB:PAGE_LSB]; // see RQ1, see RQ3
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sfe_tmr_t bcnt_reg;
  logic     sect_run_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bcnt_reg <= TMR_ZERO;
      sect_run_reg <= 1'b0;
    end else if (start_erase) begin
      bcnt_reg <= TMR_ZERO;
      sect_run_reg <= dec_sc;
    end else if (BUSY_FLAG) begin
      bcnt_reg <= bcnt_reg + TMR_ONE;
    end
  end

  sequence s_erase_go;
    start_erase;
  endsequence

  sequence s_busy_two;
    BUSY_FLAG [*2];
  endsequence

  sequence s_wake_req;
    (state_reg == ST_SLEEP) && fr_end && dec_wake;
  endsequence

  chk_busy_start: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ5
    s_erase_go |=> s_busy_two)
    else $error("busy flag did not rise with the erase cycle");

  chk_busy_length: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ22
    $fell(BUSY_FLAG) |-> (bcnt_reg == (sect_run_reg
      ? sfe_tmr_t'(SECT_CLR_CYC) : sfe_tmr_t'(PAGE_CLR_CYC))))
    else $error("erase cycle length is wrong");

  chk_latch_clear: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ6
    s_erase_go |=> ##1 !WRITE_UNLOCK_LATCH && BUSY_FLAG)
    else $error("unlock latch still set during erase");

  chk_locked_erase: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ2
    (fr_end && idle_ok && (dec_pg || dec_sc) && !unlk_reg)
      |=> !BUSY_FLAG ##1 !BUSY_FLAG)
    else $error("erase ran without the unlock latch");

  chk_prot_block: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ8
    (fr_end && idle_ok && prot_hit) |=> !BUSY_FLAG)
    else $error("protected area was erased");

  chk_busy_reject: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ9
    (BUSY_FLAG && fr_end && (tmr_reg > TMR_ONE))
      |=> BUSY_FLAG && !DEEP_SLEEP && $stable(ERASE_PAGE))
    else $error("frame disturbed a running cycle");

  chk_sleep_block: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ12
    (DEEP_SLEEP && fr_end) |=> !BUSY_FLAG && !ERASE_STB)
    else $error("instruction acted in deep sleep");

  chk_wake_len: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ15
    ((state_reg == ST_SLEEP) && fr_end && !dec_wake) |=> DEEP_SLEEP)
    else $error("bad wake frame left deep sleep");

  chk_wake_exit: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ16
    s_wake_req |=> !DEEP_SLEEP ##1 (state_reg == ST_WAKE))
    else $error("wake frame did not start the wake delay");

  chk_lockout: assert property (@(posedge CLK) disable iff (!RST_N) // see RQ18
    LOCKOUT |-> !WRITE_UNLOCK_LATCH && !BUSY_FLAG)
    else $error("modifying instruction taken during lockout");

  chk_power_up: assert property (@(posedge CLK) // see RQ20
    !RST_N |=> !BUSY_FLAG && !WRITE_UNLOCK_LATCH && !DEEP_SLEEP)
    else $error("power-up state is not clean standby");

  // the array must see one strobe per accepted erase, never a held level
  chk_stb_once: assert property ( // see RQ1, see RQ7
    @(posedge CLK) disable iff (!RST_N)
    ERASE_STB |=> !ERASE_STB)
    else $error("erase strobe longer than one cycle");

  chk_sleep_entry: assert property ( // see RQ11, see RQ13
    @(posedge CLK) disable iff (!RST_N)
    $rose(DEEP_SLEEP) |-> (state_reg == ST_SLEEP) &&
      ($past(state_reg) == ST_SLEEP_ENTRY))
    else $error("deep sleep entered without a sleep frame");

endmodule

/* test/sfe_host_model.sv */
// host-side serial master model that frames instructions for the sequencer
`timescale 1ns/100ps
module sfe_host_model
  import sfe_pkg::*;
#(
  parameter int HALF_NS = 32,
  parameter int GAP_NS  = 200
) (
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  logic ready;

  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    sdi   = 1'b1;
    ready = 1'b0;
    #(SEL_AFTER_US * 1000);
    ready = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock stands still between frames; the data line flips on
  // deselect so a stale bit is never mistaken for a driven one
  task automatic send(input int nbits, input logic [39:0] bits);
    int i;
    wait (ready);
    #(GAP_NS);
    #7;
    cs_n = 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      sdi = bits[i];
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    sdi  = ~sdi;
  endtask
endmodule

/* test/sfe_ctrl_tb.sv */
// self-checking bench for the erase, deep sleep and lockout sequencer
`timescale 1ns/100ps
module sfe_ctrl_tb;
  import sfe_pkg::*;
  localparam int PG_CYC = PAGE_CLR_CYC_DEF;
  localparam int SC_CYC = 96;
  localparam int LIMIT  = 20000;

  logic        CLK;
  logic        RST_N;
  logic        PROT_SECT0;
  logic        EXT_CYCLE_BUSY;
  wire         SCLK;
  wire         CS_N;
  wire         SDI;
  wire         BUSY_FLAG;
  wire         WRITE_UNLOCK_LATCH;
  wire         DEEP_SLEEP;
  wire         STANDBY;
  wire         LOCKOUT;
  wire         ERASE_STB;
  wire         ERASE_SECTOR;
  wire  [10:0] ERASE_PAGE;
  int          error_cnt;
  int          check_count;
  int          cyc_cnt;

  sfe_host_model host (.sclk(SCLK), .cs_n(CS_N), .sdi(SDI));

  // lockout shortened so the run stays brief; still longer than the
  // host's select-after-supply wait, so an early unlock can be tried
  sfe_ctrl #(.SECT_CLR_CYC(SC_CYC), .LOCKOUT_CYC(1000)) uut (
    .CLK(CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI),
    .PROT_SECT0(PROT_SECT0), .EXT_CYCLE_BUSY(EXT_CYCLE_BUSY),
    .BUSY_FLAG(BUSY_FLAG), .WRITE_UNLOCK_LATCH(WRITE_UNLOCK_LATCH),
    .DEEP_SLEEP(DEEP_SLEEP), .STANDBY(STANDBY), .LOCKOUT(LOCKOUT),
    .ERASE_STB(ERASE_STB), .ERASE_SECTOR(ERASE_SECTOR),
    .ERASE_PAGE(ERASE_PAGE));

  always #20 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one erase attempt; a refused one must leave busy low
  task automatic erase(input logic [7:0] op, input logic [23:0] adr,
                       input int nb, input logic unl, input logic go,
                       input int cyc);
    int   n;
    logic sec;
    sec = (op == OPC_SC_CLR);
    if (unl) begin
      host.send(8, 40'(OPC_UNLOCK));
    end
    host.send(nb, {7'h00, op, adr, 1'b0} >> (33 - nb));
    n = 0;
    while (ERASE_STB !== 1'b1 && n < 12) begin
      tick(1);
      n++;
    end
    if (!go) begin
      chk(BUSY_FLAG === 1'b0, "erase ran although refused");
      return;
    end
    chk(BUSY_FLAG === 1'b1 && ERASE_STB === 1'b1,
        "erase did not start");
    chk(ERASE_SECTOR === sec, "erase kind");
    chk(sec ? ERASE_PAGE[10:8] === adr[18:16]
            : ERASE_PAGE === adr[18:8], "erase target");
    fork
      host.send(8, 40'(OPC_SLEEP));
    join_none
    tick(1);
    chk(ERASE_STB === 1'b0, "strobe held too long");
    n = 1;
    while (BUSY_FLAG === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(n == cyc, "busy length");
    chk(WRITE_UNLOCK_LATCH === 1'b0, "latch kept");
    tick(30);
    chk(DEEP_SLEEP === 1'b0, "sleep taken while busy");
  endtask

  always @(posedge CLK) begin
    cyc_cnt++;
    if (cyc_cnt > LIMIT) begin
      error_cnt++;
      $display("MISMATCH at %0t: run hung", $time);
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    CLK            = 1'b0;
    RST_N          = 1'b0;
    PROT_SECT0     = 1'b0;
    EXT_CYCLE_BUSY = 1'b0;
    error_cnt      = 0;
    check_count    = 0;
    cyc_cnt        = 0;
    tick(12);
    chk(BUSY_FLAG === 1'b0 && WRITE_UNLOCK_LATCH === 1'b0 &&
        DEEP_SLEEP === 1'b0 && ERASE_STB === 1'b0, "reset");
    RST_N = 1'b1;
    tick(6);
    chk(STANDBY === 1'b1, "no standby after reset");
    host.send(8, 40'(OPC_UNLOCK));
    tick(10);
    chk(WRITE_UNLOCK_LATCH === 1'b0 && LOCKOUT === 1'b1, "early unlock");
    n = 0;
    while (LOCKOUT !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk(LOCKOUT === 1'b0, "lockout stuck");
    $display("test power-up lockout done");
    erase(OPC_PG_CLR, 24'hFB_A5C3, 32, 1'b0, 1'b0, 0);
    erase(OPC_PG_CLR, 24'hFB_A5C3, 32, 1'b1, 1'b1, PG_CYC);
    erase(OPC_PG_CLR, 24'h01_2345, 33, 1'b1, 1'b0, 0);
    erase(OPC_SC_CLR, 24'hF5_1234, 32, 1'b1, 1'b1, SC_CYC);
    PROT_SECT0 = 1'b1;
    erase(OPC_SC_CLR, 24'h00_8000, 32, 1'b1, 1'b0, 0);
    erase(OPC_PG_CLR, 24'hF8_0100, 32, 1'b1, 1'b0, 0);
    erase(OPC_PG_CLR, 24'h03_0000, 32, 1'b1, 1'b1, PG_CYC);
    PROT_SECT0     = 1'b0;
    // latch set first, so only the foreign cycle can block this erase
    host.send(8, 40'(OPC_UNLOCK));
    tick(10);
    chk(WRITE_UNLOCK_LATCH === 1'b1, "unlock not taken");
    EXT_CYCLE_BUSY = 1'b1;
    erase(OPC_PG_CLR, 24'h03_0000, 32, 1'b0, 1'b0, 0);
    EXT_CYCLE_BUSY = 1'b0;
    $display("test erase done");
    host.send(9, 40'({OPC_SLEEP, 1'b0}));
    tick(20);
    chk(DEEP_SLEEP === 1'b0, "long sleep frame taken");
    host.send(8, 40'(OPC_SLEEP));
    tick(4);
    chk(DEEP_SLEEP === 1'b0, "sleep too early");
    n = 4;
    while (DEEP_SLEEP !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n >= SLEEP_CYC_DEF + 2 && n <= SLEEP_CYC_DEF + 6, "sleep delay");
    erase(OPC_PG_CLR, 24'h03_0000, 32, 1'b1, 1'b0, 0);
    host.send(9, 40'({OPC_WAKE, 1'b0}));
    tick(20);
    chk(DEEP_SLEEP === 1'b1, "long wake frame taken");
    host.send(8, 40'(OPC_WAKE));
    n = 0;
    while (DEEP_SLEEP !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    chk(DEEP_SLEEP === 1'b0 && STANDBY === 1'b0, "wake start");
    n = 0;
    while (STANDBY !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk(n == WAKE_CYC_DEF, "wake delay");
    $display("test sleep and wake done");
    host.send(8, 40'(OPC_SLEEP));
    tick(20);
    chk(DEEP_SLEEP === 1'b1, "no sleep");
    RST_N = 1'b0;
    tick(3);
    chk(DEEP_SLEEP === 1'b0 && LOCKOUT === 1'b1 &&
        WRITE_UNLOCK_LATCH === 1'b0, "reset in sleep");
    RST_N = 1'b1;
    tick(6);
    chk(STANDBY === 1'b1 && BUSY_FLAG === 1'b0, "standby after reset");
    $display("test reset in sleep done");
    test_done();
  end
endmodule
